/* File: design/mic_consts.svh */
`ifndef MIC_CONSTS_SVH
`define MIC_CONSTS_SVH
// register offsets (8-bit byte addresses)
`define MIC_ADDR_CTRL1    8'h00
`define MIC_ADDR_CTRL2    8'h01
`define MIC_ADDR_PSTAT    8'h02
`define MIC_ADDR_PEN      8'h03
`define MIC_ADDR_IRQ_ST   8'h04
`define MIC_ADDR_IRQ_MSK  8'h05
`define MIC_ADDR_VEC_HI   8'h06
`define MIC_ADDR_VEC_LO   8'h07
`define MIC_ADDR_ASSOC0   8'h08
// sensitivity encodings
`define MIC_SENS_FALL_LOW 2'h0
`define MIC_SENS_RISE     2'h1
`define MIC_SENS_FALL     2'h2
`define MIC_SENS_BOTH     2'h3
// source counts and numbers
`define MIC_NSRC          12
`define MIC_NEXT          5
`define MIC_NPER          6
`define MIC_NPIN          4
// vector addresses
`define MIC_VEC_RESET     16'hFFFE
`define MIC_VEC_TRAP      16'hFFFC
`define MIC_VEC_BASE      16'hFFFA
`define MIC_VEC_NONE      16'h0000
// halt wake capability per source number 0..11
`define MIC_WAKE_MASK     12'hA6F
`define MIC_ZERO8         8'h00
`define MIC_ZERO12        12'h000
`endif

/* File: design/mic_pkg.sv */
package mic_pkg;
    // bus request from the core register port
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } mic_bus_s;
    // vector offered to the core
    typedef struct packed {
        logic        valid;
        logic [3:0]  num;
        logic [15:0] addr;
    } mic_vec_s;
    typedef enum logic [1:0] {
        MIC_SEL_NONE,
        MIC_SEL_RESET,
        MIC_SEL_TRAP,
        MIC_SEL_SRC
    } mic_sel_e;
endpackage

/* File: design/mic_irq_ctrl.sv */
`timescale 1ns/1ps
`include "mic_consts.svh"
// Behaviour
// R1 - external vector reaches core only when request pending and global mask clear
// R2 - pending external request wakes the core from halt
// R3 - edge requests latch, cleared automatically on service routine entry
// R4 - software picks each external source polarity via control registers
// R5 - any low nand pin enabled in nand_pin_en blocks the combined source, even rising-edge mode
// R6 - peripheral request raised when flag active, mask clear, enable set
// R7 - peripheral request stays latched until mask and enable allow it
// R8 - writing zero to a status flag bit clears that peripheral request
// R9 - status read with flag set, then associated access, clears request
// R10 - clearing resets latch; disabled pending request is lost
// R11 - timer compare is vector 8 at FFEAh, no halt wake
// R12 - timer overflow is vector 9 at FFE8h, may wake halt
// R13 - small timer capture is vector 10 at FFE6h, no halt wake
// R14 - periodic tick is vector 11 at FFE4h, may wake halt
// R15 - sensitivity 00 fall+low, 01 rise, 10 fall, 11 both edges
// R16 - changing a source sensitivity clears its pending request
// R17 - sensitivity writes accepted only while global mask bit is set
// R18 - lowest pending vector number wins; reset and trap come first
module mic_irq_ctrl
    import mic_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 resetn,
    input  wire logic [`MIC_NEXT-1:0] ext_pin,
    input  wire logic [`MIC_NPIN-1:0] nand_pin,
    input  wire logic [`MIC_NPIN-1:0] nand_pin_en,
    input  wire logic [`MIC_NPER-1:0] per_event,
    input  wire logic                 glob_mask,
    input  wire logic                 trap_req,
    input  wire logic                 reset_vec_req,
    input  wire logic                 isr_enter,
    input  wire logic [3:0]           isr_num,
    input  wire logic [7:0]           addr,
    input  wire logic [7:0]           wdata,
    input  wire logic                 wr,
    input  wire logic                 rd,
    output logic      [7:0]           rdata,
    output logic                      vec_valid,
    output logic      [3:0]           vec_num,
    output logic      [15:0]          vec_addr,
    output logic                      wake,
    output logic                      irq
);
    // peripheral index 0..5 maps to source numbers 0,7,8,9,10,11
    localparam logic [3:0] PER_NUM [`MIC_NPER] =
        '{4'h0, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB};
    // external index 0..4 maps to source numbers 1,2,3,5,6
    localparam logic [3:0] EXT_NUM [`MIC_NEXT] =
        '{4'h1, 4'h2, 4'h3, 4'h5, 4'h6};

    mic_bus_s bus;
    assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

    // pin synchronisers, two stages before any use
    logic [`MIC_NEXT-1:0] ext_s1_r;
    logic [`MIC_NEXT-1:0] ext_s2_r;
    logic [`MIC_NEXT-1:0] ext_d_r;
    logic [`MIC_NPIN-1:0] nand_s1_r;
    logic [`MIC_NPIN-1:0] nand_s2_r;
    // reset to the idle high level so no false edge follows reset
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ext_s1_r <= '1;
            ext_s2_r <= '1;
        end
        else
        begin
            ext_s1_r <= ext_pin;
            ext_s2_r <= ext_s1_r;
        end
    end

    // merged port pins, same two-stage treatment
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            nand_s1_r <= '1;
            nand_s2_r <= '1;
        end
        else
        begin
            nand_s1_r <= nand_pin;
            nand_s2_r <= nand_s1_r;
        end
    end

    // nand pins merge into source 0 of the external group
    wire nand_low = |(~nand_s2_r & nand_pin_en);
    wire [`MIC_NEXT-1:0] ext_lvl;
    wire [`MIC_NEXT-1:0] ext_prev;
    assign ext_lvl  = {ext_s2_r[`MIC_NEXT-1:1], ext_s2_r[0] & ~nand_low}; // R5
    assign ext_prev = ext_d_r;

    // history of the gated level, so a held nand pin cannot fake
    // an edge on line 0 or hide the one its release makes
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            ext_d_r <= '1;
        else
            ext_d_r <= ext_lvl;
    end

    // sensitivity control, two bits per external line
    logic [7:0] ctrl1_r;
    logic [7:0] ctrl2_r;
    wire ctrl_wr_ok = glob_mask; // R17
    wire wr_c1 = bus.wr && bus.addr == `MIC_ADDR_CTRL1 && ctrl_wr_ok;
    wire wr_c2 = bus.wr && bus.addr == `MIC_ADDR_CTRL2 && ctrl_wr_ok;
    wire [9:0] sens_all = {ctrl2_r[3:0], ctrl1_r[5:0]};
    wire [9:0] sens_new = {wr_c2 ? bus.wdata[3:0] : ctrl2_r[3:0],
                           wr_c1 ? bus.wdata[5:0] : ctrl1_r[5:0]};
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ctrl1_r <= `MIC_ZERO8;
            ctrl2_r <= `MIC_ZERO8;
        end
        else
        begin
            if (wr_c1)
                ctrl1_r <= bus.wdata; // R4
            if (wr_c2)
                ctrl2_r <= {4'h0, bus.wdata[3:0]}; // R4
        end
    end

    // peripheral flags, enables and latches
    logic [`MIC_NPER-1:0] pstat_r;
    logic [`MIC_NPER-1:0] pen_r;
    logic [`MIC_NPER-1:0] armed_r;   // status read seen while flag set
    wire wr_pstat = bus.wr && bus.addr == `MIC_ADDR_PSTAT;
    wire rd_pstat = bus.rd && bus.addr == `MIC_ADDR_PSTAT;
    wire wr_pen   = bus.wr && bus.addr == `MIC_ADDR_PEN;

    // request latches, one per external line
    logic [`MIC_NEXT-1:0] ext_pend_r;
    wire  [`MIC_NEXT-1:0] ext_req;
    wire  [`MIC_NEXT-1:0] ext_serv;
    wire  [`MIC_NPER-1:0] per_clr;

    genvar g;
    generate
        for (g = 0; g < `MIC_NEXT; g++)
        begin : g_ext
            wire [1:0] sens = sens_all[2*g +: 2];
            wire rise = ext_lvl[g] & ~ext_prev[g];
            wire fall = ~ext_lvl[g] & ext_prev[g];
            wire edge_hit =
                (sens == `MIC_SENS_RISE) ? rise :
                (sens == `MIC_SENS_FALL) ? fall :
                (sens == `MIC_SENS_BOTH) ? (rise | fall) :
                fall; // R15
            wire sens_chg = sens_new[2*g +: 2] != sens; // R16
            assign ext_serv[g] = isr_enter && isr_num == EXT_NUM[g];
            // low level in mode 00 requests while held, no latch needed
            wire low_req = (sens == `MIC_SENS_FALL_LOW) & ~ext_lvl[g]; // R15
            // a fresh edge wins over a clear landing in the same cycle
            always_ff @(posedge clk or negedge resetn)
            begin
                if (!resetn)
                    ext_pend_r[g] <= 1'b0;
                else if (edge_hit)
                    ext_pend_r[g] <= 1'b1; // R3
                else if (sens_chg)
                    ext_pend_r[g] <= 1'b0; // R16
                else if (ext_serv[g])
                    ext_pend_r[g] <= 1'b0; // R3
            end
            // nand group: a low pin masks even a latched request
            wire blk = (g == 0) && nand_low; // R5
            assign ext_req[g] = (ext_pend_r[g] | low_req) & ~blk;
        end
        for (g = 0; g < `MIC_NPER; g++)
        begin : g_per
            wire wr_assoc = (bus.wr || bus.rd) &&
                            bus.addr == (`MIC_ADDR_ASSOC0 + 8'(g));
            // zero write or read-then-access sequence clears the latch
            assign per_clr[g] = (wr_pstat && !bus.wdata[g]) || // R8
                                (armed_r[g] && wr_assoc);       // R9
            always_ff @(posedge clk or negedge resetn)
            begin
                if (!resetn)
                begin
                    pstat_r[g] <= 1'b0;
                    armed_r[g] <= 1'b0;
                end
                else
                begin
                    // new event wins over a clear in the same cycle
                    if (per_event[g])
                        pstat_r[g] <= 1'b1; // R7
                    else if (per_clr[g])
                        pstat_r[g] <= 1'b0; // R10
                    if (per_clr[g])
                        armed_r[g] <= 1'b0;
                    else if (rd_pstat && pstat_r[g])
                        armed_r[g] <= 1'b1; // R9
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            pen_r <= '0;
        else if (wr_pen)
            pen_r <= bus.wdata[`MIC_NPER-1:0];
    end

    // collect per source number; unused numbers stay zero
    logic [`MIC_NSRC-1:0] src_req;
    always_comb
    begin
        src_req = `MIC_ZERO12;
        for (int i = 0; i < `MIC_NEXT; i++)
            src_req[EXT_NUM[i]] = ext_req[i];
        for (int i = 0; i < `MIC_NPER; i++)
            src_req[PER_NUM[i]] = pstat_r[i] & pen_r[i]; // R6
    end

    // global mask gates delivery but never drops the latch
    wire [`MIC_NSRC-1:0] src_live = glob_mask ? `MIC_ZERO12 : src_req; // R1 R7

    // fixed priority: lowest number first
    logic [3:0] win_num;
    logic       win_any;
    always_comb
    begin
        win_num = 4'h0;
        win_any = 1'b0;
        for (int i = `MIC_NSRC-1; i >= 0; i--)
            if (src_live[i])
            begin
                win_num = 4'(i); // R18
                win_any = 1'b1;
            end
    end

    mic_sel_e sel;
    assign sel = reset_vec_req ? MIC_SEL_RESET :
                 trap_req      ? MIC_SEL_TRAP  :
                 win_any       ? MIC_SEL_SRC   : MIC_SEL_NONE; // R18
    // vector n sits at base minus 2n: 8->FFEA .. 11->FFE4
    wire [15:0] src_addr = `MIC_VEC_BASE - {11'h0, win_num, 1'b0}; // R11 R12 R13 R14

    mic_vec_s vec_nxt;
    always_comb
    begin
        case (sel)
            MIC_SEL_RESET: vec_nxt = '{1'b1, 4'h0, `MIC_VEC_RESET};
            MIC_SEL_TRAP:  vec_nxt = '{1'b1, 4'h0, `MIC_VEC_TRAP};
            MIC_SEL_SRC:   vec_nxt = '{1'b1, win_num, src_addr};
            default:       vec_nxt = '{1'b0, 4'h0, `MIC_VEC_NONE};
        endcase
    end

    // halt wake ignores the global mask so a masked source still wakes
    wire [`MIC_NSRC-1:0] wake_mask = `MIC_WAKE_MASK; // R11 R12 R13 R14
    wire wake_nxt = |(src_req & wake_mask) | (|ext_req); // R2

    // sticky event status for the interrupt output
    logic [`MIC_NSRC-1:0] ist_r;
    logic [`MIC_NSRC-1:0] imsk_r;
    logic [7:0]           rdata_nxt;
    logic [`MIC_NSRC-1:0] req_d_r;
    // only a new request is an event, so a write-one clear sticks
    // even while the request itself stays pending
    wire  [`MIC_NSRC-1:0] req_rise = src_req & ~req_d_r;
    wire wr_ist  = bus.wr && bus.addr == `MIC_ADDR_IRQ_ST;
    wire wr_imsk = bus.wr && bus.addr == `MIC_ADDR_IRQ_MSK;
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ist_r  <= `MIC_ZERO12;
            imsk_r <= `MIC_ZERO12;
            req_d_r <= `MIC_ZERO12;
        end
        else
        begin
            // set wins over a write-one clear
            ist_r <= (ist_r & ~(wr_ist ? {4'h0, bus.wdata} : `MIC_ZERO12))
                     | req_rise;
            req_d_r <= src_req;
            if (wr_imsk)
                imsk_r <= {4'h0, bus.wdata};
        end
    end

    // read mux; unmapped addresses read zero
    always_comb
    begin
        case (bus.addr)
            `MIC_ADDR_CTRL1:   rdata_nxt = ctrl1_r;
            `MIC_ADDR_CTRL2:   rdata_nxt = ctrl2_r;
            `MIC_ADDR_PSTAT:   rdata_nxt = {2'h0, pstat_r};
            `MIC_ADDR_PEN:     rdata_nxt = {2'h0, pen_r};
            `MIC_ADDR_IRQ_ST:  rdata_nxt = ist_r[7:0];
            `MIC_ADDR_IRQ_MSK: rdata_nxt = imsk_r[7:0];
            `MIC_ADDR_VEC_HI:  rdata_nxt = vec_addr[15:8];
            `MIC_ADDR_VEC_LO:  rdata_nxt = vec_addr[7:0];
            default:           rdata_nxt = `MIC_ZERO8;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            rdata <= `MIC_ZERO8;
        else
            rdata <= bus.rd ? rdata_nxt : `MIC_ZERO8;
    end

    // vector offer, one cycle behind the request state
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            vec_valid <= 1'b0;
            vec_num   <= 4'h0;
            vec_addr  <= `MIC_VEC_NONE;
        end
        else
        begin
            vec_valid <= vec_nxt.valid;
            vec_num   <= vec_nxt.num;
            vec_addr  <= vec_nxt.addr;
        end
    end

    // wake and interrupt levels, registered like the vector
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wake <= 1'b0;
            irq  <= 1'b0;
        end
        else
        begin
            wake <= wake_nxt;
            irq  <= |(ist_r & imsk_r);
        end
    end
endmodule

/* File: testbench/mic_irq_ctrl_sva.sv */
`timescale 1ns/1ps
module mic_irq_ctrl_sva
    import mic_pkg::*;
(
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        glob_mask,
    input wire logic        trap_req,
    input wire logic        reset_vec_req,
    input wire logic [7:0]  addr,
    input wire logic [7:0]  wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [7:0]  rdata,
    input wire logic        vec_valid,
    input wire logic [3:0]  vec_num,
    input wire logic [15:0] vec_addr
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    logic [7:0] sens_r;
    // shadow of ctrl1, refused writes leave it alone
    always_ff @(posedge clk or negedge resetn)
        if (!resetn)
            sens_r <= 8'h00;
        else if (wr && addr == 8'h00 && glob_mask)
            sens_r <= wdata;
    // source vectors step down two bytes per number
    vec_map_a: assert property (
        vec_valid && vec_addr <= 16'hFFFA |->
        vec_addr == 16'hFFFA - {11'h000, vec_num, 1'h0})
        else $error("source vector address wrong");
    vec_range_a: assert property (
        vec_valid && vec_addr <= 16'hFFFA |-> vec_num <= 4'hB && vec_num != 4'h4)
        else $error("unused source number offered");
    // held two cycles so either pipeline depth is covered
    reset_first_a: assert property (
        reset_vec_req [*2] |=> vec_valid && vec_addr == 16'hFFFE)
        else $error("reset vector not first");
    trap_first_a: assert property (
        (trap_req && !reset_vec_req && !glob_mask) [*2] |=> vec_addr == 16'hFFFC)
        else $error("trap vector not ahead of sources");
    mask_block_a: assert property (
        (glob_mask && !trap_req && !reset_vec_req) [*2] |=> !vec_valid)
        else $error("vector offered while masked");
    rd_idle_a: assert property (!rd |=> rdata == 8'h00)
        else $error("read data outside read slot");
    unmapped_rd_a: assert property (rd && addr > 8'h0D |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    sens_keep_a: assert property (
        rd && addr == 8'h00 |=> rdata[5:0] == sens_r[5:0])
        else $error("sensitivity readback wrong");
endmodule

bind mic_irq_ctrl mic_irq_ctrl_sva u_sva (.clk, .resetn, .glob_mask,
    .trap_req, .reset_vec_req, .addr, .wdata, .wr, .rd, .rdata,
    .vec_valid, .vec_num, .vec_addr);

/* File: testbench/mic_cpu_model.sv */
`timescale 1ns/1ps
module mic_cpu_model
    import mic_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       ack_en,
    input  wire logic       vec_valid,
    input  wire logic [3:0] vec_num,
    output logic            isr_enter,
    output logic      [3:0] isr_num
);
    logic [1:0] gap_r;
    wire        take = ack_en && vec_valid && gap_r == 2'h0;
    // number captured with the entry; two idle cycles let the latch
    // drop and the stale offer clear before another entry
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            isr_enter <= 1'b0;
            isr_num   <= 4'h0;
            gap_r     <= 2'h0;
        end
        else
        begin
            isr_enter <= take;
            isr_num   <= vec_num;
            gap_r     <= take ? 2'h2 : gap_r - {1'b0, gap_r != 2'h0};
        end
    end
endmodule

/* File: testbench/tb.sv */
`timescale 1ns/1ps
module tb
    import mic_pkg::*;
;
    typedef struct packed {
        logic [2:0]  idx;
        logic [3:0]  num;
        logic        wk;
        logic [15:0] va;
    } mic_row_s;
    logic        clk = 1'b0, resetn = 1'b0, glob_mask = 1'b0;
    logic        trap_req = 1'b0, reset_vec_req = 1'b0, ack_en = 1'b0;
    logic        wr = 1'b0, rd = 1'b0, isr_enter, vec_valid, wake, irq;
    logic [4:0]  ext_pin = 5'h1F;
    logic [3:0]  nand_pin = 4'hF, nand_pin_en = 4'h0, isr_num, vec_num;
    logic [5:0]  per_event = 6'h00;
    logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata;
    logic [15:0] vec_addr;
    int          num_errors = 0, n_tests = 0, cyc = 0;
    mic_row_s    rows [6] = '{'{3'h0, 4'h0, 1'h1, 16'hFFFA},
        '{3'h1, 4'h7, 1'h0, 16'hFFEC}, '{3'h2, 4'h8, 1'h0, 16'hFFEA},
        '{3'h3, 4'h9, 1'h1, 16'hFFE8}, '{3'h4, 4'hA, 1'h0, 16'hFFE6},
        '{3'h5, 4'hB, 1'h1, 16'hFFE4}};
    mic_irq_ctrl u_mic_irq_ctrl (.clk, .resetn, .ext_pin, .nand_pin,
        .nand_pin_en, .per_event, .glob_mask, .trap_req, .reset_vec_req,
        .isr_enter, .isr_num, .addr, .wdata, .wr, .rd, .rdata, .vec_valid,
        .vec_num, .vec_addr, .wake, .irq);
    mic_cpu_model u_mic_cpu_model (.clk, .resetn, .ack_en, .vec_valid,
        .vec_num, .isr_enter, .isr_num);
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic pulse(input logic [5:0] m);
        @(posedge clk);
        per_event <= m;
        @(posedge clk);
        per_event <= 6'h00;
    endtask
    // core takes whatever is offered for a few cycles
    task automatic ack();
        @(posedge clk);
        ack_en <= 1'b1;
        repeat (3) @(posedge clk);
        ack_en <= 1'b0;
        tick(4);
    endtask
    task automatic summarize();
        $display("errors %0d checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always #5 clk = ~clk;
    // run is well under a thousand cycles, so a hang stops early
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            num_errors++;
            $display("ERROR %0t: timeout", $time);
            summarize();
        end
    end
    initial
    begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        rreg(8'h20, 8'h00);
        wreg(8'h03, 8'h3F);
        // each peripheral source, its vector and wake ability
        foreach (rows[i])
        begin
            pulse(6'h01 << rows[i].idx);
            tick(4);
            chk(vec_valid, 1'h1);
            chk(vec_num, rows[i].num);
            chk(vec_addr, rows[i].va);
            chk(wake, rows[i].wk);
            wreg(8'h02, ~(8'h01 << rows[i].idx));
            tick(3);
            chk(vec_valid, 1'h0);
        end
        // disabled request waits, status read plus access drops it
        wreg(8'h03, 8'h00);
        pulse(6'h08);
        tick(4);
        chk(vec_valid, 1'h0);
        wreg(8'h03, 8'h3F);
        tick(3);
        chk(vec_num, 4'h9);
        rreg(8'h02, 8'h08);
        wreg(8'h0B, 8'h00);
        tick(3);
        chk(vec_valid, 1'h0);
        wreg(8'h03, 8'h00);
        pulse(6'h08);
        wreg(8'h02, 8'hF7);
        wreg(8'h03, 8'h3F);
        tick(3);
        chk(vec_valid, 1'h0);
        // two at once under the mask, then trap and reset on top
        @(posedge clk) glob_mask <= 1'b1;
        pulse(6'h24);
        tick(4);
        chk(vec_valid, 1'h0);
        @(posedge clk) glob_mask <= 1'b0;
        tick(3);
        chk(vec_num, 4'h8);
        @(posedge clk) trap_req <= 1'b1;
        tick(3);
        chk(vec_addr, 16'hFFFC);
        @(posedge clk) reset_vec_req <= 1'b1;
        tick(3);
        chk(vec_addr, 16'hFFFE);
        @(posedge clk) {trap_req, reset_vec_req} <= 2'h0;
        wreg(8'h02, 8'hFB);
        tick(3);
        chk(vec_num, 4'hB);
        wreg(8'h02, 8'h00);
        // ext3 rising, ext4 falling, ext0 rising; unmasked write refused
        @(posedge clk) glob_mask <= 1'b1;
        wreg(8'h01, 8'h09);
        wreg(8'h00, 8'h01);
        @(posedge clk) glob_mask <= 1'b0;
        wreg(8'h01, 8'h00);
        rreg(8'h01, 8'h09);
        rreg(8'h00, 8'h01);
        @(posedge clk) ext_pin[3] <= 1'b0;
        tick(6);
        chk(vec_valid, 1'h0);
        @(posedge clk) ext_pin[3] <= 1'b1;
        tick(6);
        chk(vec_num, 4'h5);
        chk(wake, 1'h1);
        ack();
        chk(vec_valid, 1'h0);
        // pending fall on ext4 dropped by a mode change, then low level
        @(posedge clk) glob_mask <= 1'b1;
        ext_pin[4] <= 1'b0;
        tick(6);
        wreg(8'h01, 8'h05);
        @(posedge clk) glob_mask <= 1'b0;
        tick(3);
        chk(vec_valid, 1'h0);
        @(posedge clk) glob_mask <= 1'b1;
        wreg(8'h01, 8'h01);
        @(posedge clk) glob_mask <= 1'b0;
        tick(6);
        ack();
        chk(vec_num, 4'h6);
        @(posedge clk) ext_pin[4] <= 1'b1;
        tick(6);
        ack();
        chk(vec_valid, 1'h0);
        // a low merged pin hides the rising edge on ext0
        @(posedge clk) nand_pin_en <= 4'h1;
        nand_pin <= 4'hE;
        ext_pin[0] <= 1'b0;
        tick(6);
        @(posedge clk) ext_pin[0] <= 1'b1;
        tick(6);
        chk(vec_valid, 1'h0);
        @(posedge clk) nand_pin <= 4'hF;
        ext_pin[0] <= 1'b0;
        tick(6);
        @(posedge clk) ext_pin[0] <= 1'b1;
        tick(6);
        chk(vec_num, 4'h1);
        ack();
        // sticky status, mask and the level output
        wreg(8'h04, 8'hFF);
        wreg(8'h05, 8'h80);
        pulse(6'h02);
        tick(4);
        chk(irq, 1'h1);
        wreg(8'h04, 8'h80);
        tick(3);
        chk(irq, 1'h0);
        wreg(8'h05, 8'h00);
        wreg(8'h02, 8'hFD);
        pulse(6'h02);
        tick(4);
        chk(irq, 1'h0);
        rreg(8'h04, 8'h80);
        // reset in mid-run with a request pending
        @(posedge clk) resetn <= 1'b0;
        tick(2);
        chk(vec_valid, 1'h0);
        @(posedge clk) resetn <= 1'b1;
        rreg(8'h02, 8'h00);
        rreg(8'h01, 8'h00);
        summarize();
    end
endmodule
